//--- src/pps_defs.svh
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_CLK_MHZ 200
`define PPS_MS_US 1000
`define PPS_MS_CYC (`PPS_MS_US * `PPS_CLK_MHZ)
`define PPS_GATE_SHORT_MS 7'h0A
`define PPS_GATE_LONG_MS 7'h64
`define PPS_RES_STD 13
`define PPS_RES_MAX 16
`define PPS_FIFO_DEPTH 4
`define PPS_SYNC_W 8
`define PPS_CYCLE_RST 16'h0000
`define PPS_NODE_DEF 7'h01
`define PPS_BAUD_20K 3'h0
`define PPS_BAUD_50K 3'h1
`define PPS_BAUD_125K 3'h2
`define PPS_BAUD_250K 3'h3
`define PPS_BAUD_500K 3'h4
`define PPS_BAUD_800K 3'h5
`define PPS_BAUD_1M 3'h6
`define PPS_LEN_POS 3'h2
`define PPS_LEN_SPD 3'h4
`define PPS_STRAP_WAIT 2'h3
`endif

//--- src/pps_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module pps_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] wr_idx;
    logic push;
    logic pop;

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("pps_fifo: unsupported depth or width");
    end

    // Head slot is a flop so the output needs no read mux
    assign in_ready = (cnt_r != CW'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign wr_idx = cnt_r - CW'(pop);
    assign out_data = mem[0];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            out_valid <= 1'b0;
        end else begin
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
            out_valid <= (cnt_r + CW'(push) - CW'(pop)) != '0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && i == int'(wr_idx)) begin
                    mem[i] <= in_data;
                end else if (pop && i < DEPTH - 1) begin
                    mem[i] <= mem[(i + 1) % DEPTH];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- src/pps_pkg.sv
package pps_pkg;
    typedef enum logic [1:0] {
        pps_poll = 2'b00,
        pps_cyclic = 2'b01,
        pps_sync_cyc = 2'b10,
        pps_sync_acyc = 2'b11
    } pps_mode_e;
endpackage

//--- src/pps_scheduler.sv
// Overview of operation
// R1: Polling mode sends a position frame only on a remote request.
// R2: Cyclic mode sends periodically, period programmable 1 ms to 65536 ms.
// R3: Synchronous-cyclic mode sends on sync messages.
// R4: Sync counter holds off until N syncs, sends on the last, restarts.
// R5: Synchronous-acyclic mode sends on sync only if position changed since last frame.
// R6: Configuration write selects one of the four transmission modes.
// R7: Enable bit turns on speed measurement and speed in frame.
// R8: Gate bit selects 10 ms (0) or 100 ms (1) speed gate.
// R9: Speed is 16-bit position change over the gate, independent of resolution.
// R10: Each new speed value is published to the process-data path.
// R11: Without speed, payload is two bytes of position, LSB first.
// R12: With speed, payload is four bytes: position then speed.
// R13: Speed sits in bytes 2 and 3, LSB first.
// R14: Position resolution defaults to 13 bits, options up to 16.
// R15: Node address 1 to 127, default 1, from switches or layer service.
// R16: Layer service bit rates 20 to 1000 kbit/s, default 20.
// R17: Switch bit rates limited to 20, 125, 500 and 1000 kbit/s.
// R18: Storage fault and checksum fault are flagged as alarms.
// R19: Cycle timer restarts on entering cyclic mode or rewriting its period.
`timescale 1ns/10ps
`default_nettype none
`include "pps_defs.svh"
module pps_scheduler #(
    parameter int MS_CYCLES = `PPS_MS_CYC,
    parameter int RES_BITS = `PPS_RES_STD,
    parameter int FIFO_DEPTH = `PPS_FIFO_DEPTH,
    parameter int SYNC_W = `PPS_SYNC_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input var pps_pkg::pps_mode_e cfg_mode,
    input wire logic [15:0] cfg_cycle_ms,
    input wire logic [SYNC_W-1:0] cfg_sync_n,
    input wire logic cfg_speed_en,
    input wire logic cfg_gate_long,
    input wire logic rtr_req,
    input wire logic sync_msg,
    input wire logic [15:0] pos_raw,
    input wire logic lss_node_wr,
    input wire logic [6:0] lss_node_id,
    input wire logic lss_baud_wr,
    input wire logic [2:0] lss_baud_sel,
    input wire logic [5:0] sw_node_id,
    input wire logic [1:0] sw_baud,
    input wire logic nvm_fault_pin,
    input wire logic crc_fault_pin,
    input wire logic alarm_clr,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [31:0] tx_data,
    output logic [2:0] tx_len,
    output logic tx_drop,
    output logic [15:0] speed_val,
    output logic speed_upd,
    output logic [6:0] node_id,
    output logic [2:0] baud_code,
    output logic alarm_nvm,
    output logic alarm_crc
);
    import pps_pkg::*;
    localparam int PW = $clog2(MS_CYCLES);
    if (RES_BITS < `PPS_RES_STD || RES_BITS > `PPS_RES_MAX || MS_CYCLES < 2 ||
        FIFO_DEPTH < 2 || SYNC_W < 1 || SYNC_W > 16) begin : g_bad
        $error("pps_scheduler: unsupported parameter");
    end
    pps_mode_e mode_r;
    logic [15:0] cycle_r;
    logic [SYNC_W-1:0] syncn_r;
    logic speed_en_r, gate_long_r;
    // R6: mode select write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= pps_poll;
            cycle_r <= `PPS_CYCLE_RST;
            syncn_r <= SYNC_W'(1);
            speed_en_r <= 1'b0;
            gate_long_r <= 1'b0;
        end else if (cfg_wr) begin
            mode_r <= cfg_mode;
            cycle_r <= cfg_cycle_ms;
            syncn_r <= cfg_sync_n;
            // R7: speed enable bit
            speed_en_r <= cfg_speed_en;
            // R8: gate select bit
            gate_long_r <= cfg_gate_long;
        end
    end
    // R14: scale 16-bit raw angle to resolution
    logic [15:0] pos_cur;
    assign pos_cur = 16'(pos_raw >> (16 - RES_BITS));
    // Cycle timer, own prescaler so the first period is never short
    logic [PW-1:0] cyc_pre_r;
    logic [15:0] cyc_cnt_r;
    logic cyc_tick, cyc_run, fire_cyc;
    assign cyc_run = (mode_r == pps_cyclic) && !cfg_wr;
    assign cyc_tick = (cyc_pre_r == PW'(MS_CYCLES - 1));
    // R2: period of cycle_r plus one ms
    assign fire_cyc = cyc_run && cyc_tick && (cyc_cnt_r == cycle_r);
    // R19: restart timer on write or mode entry
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_pre_r <= '0;
            cyc_cnt_r <= 16'h0000;
        end else if (!cyc_run) begin
            cyc_pre_r <= '0;
            cyc_cnt_r <= 16'h0000;
        end else if (cyc_tick) begin
            cyc_pre_r <= '0;
            cyc_cnt_r <= fire_cyc ? 16'h0000 : cyc_cnt_r + 16'h0001;
        end else begin
            cyc_pre_r <= cyc_pre_r + PW'(1);
        end
    end
    // Sync counter
    logic [SYNC_W-1:0] sync_cnt_r;
    logic [SYNC_W:0] sync_next, syncn_eff;
    logic sync_hit, in_sync_cyc;
    assign in_sync_cyc = (mode_r == pps_sync_cyc);
    assign sync_next = {1'b0, sync_cnt_r} + (SYNC_W + 1)'(1);
    assign syncn_eff = (syncn_r == '0) ? (SYNC_W + 1)'(1) : {1'b0, syncn_r};
    assign sync_hit = sync_next >= syncn_eff;
    // R4: count syncs, restart after the send
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_cnt_r <= '0;
        end else if (!in_sync_cyc || cfg_wr) begin
            sync_cnt_r <= '0;
        end else if (sync_msg) begin
            sync_cnt_r <= sync_hit ? '0 : sync_next[SYNC_W-1:0];
        end
    end
    logic [15:0] last_pos_r;
    logic fire_poll, fire_sync, fire_acyc, send, push_ok, fifo_in_ready;
    // R1: remote request in polling mode
    assign fire_poll = (mode_r == pps_poll) && rtr_req;
    // R3: sync message in synchronous-cyclic mode
    assign fire_sync = in_sync_cyc && sync_msg && sync_hit;
    // R5: send on sync only on a changed position
    assign fire_acyc = (mode_r == pps_sync_acyc) && sync_msg && (pos_cur != last_pos_r);
    assign send = fire_poll || fire_cyc || fire_sync || fire_acyc;
    assign push_ok = send && fifo_in_ready;
    // Speed gate; separate prescaler keeps gate phase apart from the cycle timer
    logic [PW-1:0] spd_pre_r;
    logic [6:0] spd_ms_r, gate_ms;
    logic [15:0] spd_last_r;
    logic spd_tick, gate_end, spd_run;
    assign spd_run = speed_en_r && !cfg_wr;
    assign gate_ms = gate_long_r ? `PPS_GATE_LONG_MS : `PPS_GATE_SHORT_MS;
    assign spd_tick = (spd_pre_r == PW'(MS_CYCLES - 1));
    assign gate_end = spd_run && spd_tick && (spd_ms_r == gate_ms - 7'h01);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            spd_pre_r <= '0;
            spd_ms_r <= 7'h00;
        end else if (!spd_run) begin
            spd_pre_r <= '0;
            spd_ms_r <= 7'h00;
        end else if (spd_tick) begin
            spd_pre_r <= '0;
            spd_ms_r <= gate_end ? 7'h00 : spd_ms_r + 7'h01;
        end else begin
            spd_pre_r <= spd_pre_r + PW'(1);
        end
    end
    // R9: full 16-bit difference, wraps through zero angle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            spd_last_r <= 16'h0000;
            speed_val <= 16'h0000;
            speed_upd <= 1'b0;
        end else begin
            speed_upd <= gate_end;
            if (!spd_run) begin
                spd_last_r <= pos_raw;
            end else if (gate_end) begin
                spd_last_r <= pos_raw;
                // R10: publish new speed value
                speed_val <= pos_raw - spd_last_r;
            end
        end
    end
    // Frame build
    logic [31:0] frame_data;
    logic [2:0] frame_len;
    // R11: position in bytes 0 and 1, LSB in byte 0
    // R12: four-byte payload with speed
    // R13: speed in bytes 2 and 3
    assign frame_data = speed_en_r ? {speed_val, pos_cur} : {16'h0000, pos_cur};
    assign frame_len = speed_en_r ? `PPS_LEN_SPD : `PPS_LEN_POS;
    // A full queue drops the frame rather than stalling the trigger sources
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            last_pos_r <= 16'h0000;
            tx_drop <= 1'b0;
        end else begin
            tx_drop <= send && !fifo_in_ready;
            if (push_ok) begin
                last_pos_r <= pos_cur;
            end
        end
    end
    pps_fifo #(
        .WIDTH(35),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(send),
        .in_ready(fifo_in_ready),
        .in_data({frame_len, frame_data}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_len, tx_data})
    );
    // Pin synchronisers
    logic [5:0] sw_node_m, sw_node_s;
    logic [1:0] sw_baud_m, sw_baud_s, flt_m, flt_s;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sw_node_m <= 6'h00;
            sw_node_s <= 6'h00;
            sw_baud_m <= 2'h0;
            sw_baud_s <= 2'h0;
            flt_m <= 2'h0;
            flt_s <= 2'h0;
        end else begin
            sw_node_m <= sw_node_id;
            sw_node_s <= sw_node_m;
            sw_baud_m <= sw_baud;
            sw_baud_s <= sw_baud_m;
            flt_m <= {crc_fault_pin, nvm_fault_pin};
            flt_s <= flt_m;
        end
    end
    // R17: switch rates map onto four of the service rates
    function automatic logic [2:0] sw_rate(input logic [1:0] sel);
        case (sel)
            2'h0: sw_rate = `PPS_BAUD_20K;
            2'h1: sw_rate = `PPS_BAUD_125K;
            2'h2: sw_rate = `PPS_BAUD_500K;
            2'h3: sw_rate = `PPS_BAUD_1M;
            default: sw_rate = `PPS_BAUD_20K;
        endcase
    endfunction
    // Switches are read once, after the synchronisers have filled
    logic [1:0] strap_cnt_r;
    logic strap_done_r;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            node_id <= `PPS_NODE_DEF;
            baud_code <= `PPS_BAUD_20K;
        end else begin
            if (strap_cnt_r != `PPS_STRAP_WAIT) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
            if (!strap_done_r && strap_cnt_r == `PPS_STRAP_WAIT) begin
                strap_done_r <= 1'b1;
                // R15: zero on the switches keeps the default
                node_id <= (sw_node_s == 6'h00) ? `PPS_NODE_DEF : {1'b0, sw_node_s};
                baud_code <= sw_rate(sw_baud_s);
            end else begin
                // R15: service address accepted only in range
                if (lss_node_wr && lss_node_id != 7'h00) begin
                    node_id <= lss_node_id;
                end
                // R16: service rate codes above 1 Mbit/s refused
                if (lss_baud_wr && lss_baud_sel <= `PPS_BAUD_1M) begin
                    baud_code <= lss_baud_sel;
                end
            end
        end
    end
    // R18: sticky alarms, a new fault beats the clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            alarm_nvm <= 1'b0;
            alarm_crc <= 1'b0;
        end else begin
            alarm_nvm <= flt_s[0] || (alarm_nvm && !alarm_clr);
            alarm_crc <= flt_s[1] || (alarm_crc && !alarm_clr);
        end
    end
    // Checking helpers
    logic [47:0] cyc_gap_r;
    logic [31:0] spd_gap_r;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_gap_r <= 48'h0;
            spd_gap_r <= 32'h0;
        end else begin
            cyc_gap_r <= (!cyc_run || fire_cyc) ? 48'h0 : cyc_gap_r + 48'h1;
            spd_gap_r <= (!spd_run || gate_end) ? 32'h0 : spd_gap_r + 32'h1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence sync_arrives;
        in_sync_cyc && sync_msg && !cfg_wr;
    endsequence
    poll_only_a: assert property ((send && mode_r == pps_poll) |-> rtr_req) // R1
        else $error("poll frame without remote request");
    cyc_period_a: assert property (fire_cyc |-> // R2
        cyc_gap_r == 48'((64'(cycle_r) + 64'h1) * 64'(MS_CYCLES) - 64'h1))
        else $error("cyclic frame off period");
    sync_send_a: assert property ((sync_arrives and sync_hit) |-> send) // R3
        else $error("sync frame missing");
    sync_count_a: assert property ((sync_arrives and !sync_hit) |-> // R4
        !fire_sync ##1 (sync_cnt_r == $past(sync_cnt_r) + SYNC_W'(1)))
        else $error("sync count step wrong");
    acyc_same_a: assert property (((mode_r == pps_sync_acyc) && sync_msg && // R5
        pos_cur == last_pos_r) |-> !send)
        else $error("acyclic frame without change");
    gate_time_a: assert property (gate_end |-> spd_gap_r == // R8
        32'(int'(gate_ms) * MS_CYCLES - 1))
        else $error("speed gate length wrong");
    speed_calc_a: assert property (speed_upd |-> // R9
        speed_val == 16'($past(pos_raw) - $past(spd_last_r)))
        else $error("speed value wrong");
    short_frame_a: assert property ((tx_valid && tx_len == `PPS_LEN_POS) |-> // R11
        tx_data[31:16] == 16'h0000)
        else $error("two-byte frame carries upper bytes");
    frame_size_a: assert property (tx_valid |-> // R12
        (tx_len == `PPS_LEN_POS || tx_len == `PPS_LEN_SPD))
        else $error("frame length wrong");
    node_range_a: assert property (node_id != 7'h00) // R15
        else $error("node address zero");
    baud_range_a: assert property (baud_code <= `PPS_BAUD_1M) // R16
        else $error("bit rate code out of range");
    alarm_hold_a: assert property ($past(flt_s[0]) |-> alarm_nvm) // R18
        else $error("storage alarm lost");
    cyc_restart_a: assert property (cfg_wr |=> cyc_cnt_r == 16'h0000 && cyc_pre_r == '0) // R19
        else $error("cycle timer not restarted");
endmodule
`default_nettype wire

//--- testbench/position_pdo_scheduler_tb.sv
`timescale 1ns/10ps
`default_nettype none
module position_pdo_scheduler_tb;
    import pps_pkg::*;
    logic core_clk, nrst = 0, cfg_wr = 0, se = 0, gl = 0, rtr_req = 0, sync_msg = 0;
    pps_mode_e md = pps_poll;
    logic [15:0] cy = 0, pos_raw = 0, speed_val;
    logic [7:0] sn = 1;
    logic lnw = 0, lbw = 0, nvm = 0, crc = 0, alarm_clr = 0, stall = 0;
    logic [6:0] lid = 0, node_id;
    logic [2:0] lbs = 0, tx_len, baud_code;
    logic [5:0] sw_node = 0;
    logic [1:0] sw_baud = 0;
    logic tx_ready, tx_valid, tx_drop, speed_upd, alarm_nvm, alarm_crc;
    logic [31:0] tx_data;
    int error_cnt = 0, n_tests = 0, t0, t1;

    pps_scheduler #(.MS_CYCLES(8)) u_dut (.core_clk(core_clk), .nrst(nrst), .cfg_wr(cfg_wr),
        .cfg_mode(md), .cfg_cycle_ms(cy), .cfg_sync_n(sn), .cfg_speed_en(se),
        .cfg_gate_long(gl), .rtr_req(rtr_req), .sync_msg(sync_msg), .pos_raw(pos_raw),
        .lss_node_wr(lnw), .lss_node_id(lid), .lss_baud_wr(lbw), .lss_baud_sel(lbs),
        .sw_node_id(sw_node), .sw_baud(sw_baud), .nvm_fault_pin(nvm), .crc_fault_pin(crc),
        .alarm_clr(alarm_clr), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_len(tx_len), .tx_drop(tx_drop), .speed_val(speed_val), .speed_upd(speed_upd),
        .node_id(node_id), .baud_code(baud_code), .alarm_nvm(alarm_nvm), .alarm_crc(alarm_crc));
    pps_master_model u_mst (.core_clk(core_clk), .nrst(nrst), .stall(stall),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_len(tx_len), .tx_ready(tx_ready));

    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick();
        s = 0;
    endtask
    task automatic cfg(input pps_mode_e m, input logic [15:0] c, input logic [7:0] n,
                       input logic s, input logic g);
        md = m;
        cy = c;
        sn = n;
        se = s;
        gl = g;
        pulse(cfg_wr);
    endtask
    task automatic exp_frame(input logic [2:0] len, input logic [31:0] d);
        logic [34:0] f;
        f = '1;
        for (int i = 0; i < 60 && u_mst.fq.size() == 0; i++) tick();
        if (u_mst.fq.size() > 0) begin
            f = u_mst.fq.pop_front();
            t1 = u_mst.ft.pop_front();
        end
        chk({29'h0, f[34:32]}, {29'h0, len});
        chk(f[31:0], d);
    endtask
    task automatic nfr(input int n);
        chk(32'(u_mst.fq.size()), 32'(n));
    endtask
    task automatic wait_upd(output int t);
        for (int i = 0; i < 2000; i++) begin
            tick();
            if (speed_upd === 1'b1) break;
        end
        t = u_mst.cyc;
    endtask
    task automatic do_reset();
        nrst = 0;
        tick(2);
        chk({node_id, baud_code, tx_valid, alarm_nvm}, {7'h01, 3'h0, 2'h0});
        tick(14);
        nrst = 1;
        tick(8);
    endtask

    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            sw_baud = 2'(i);
            sw_node = 6'(i * 9);
            do_reset();
            chk(32'(node_id), (i == 0) ? 32'h1 : 32'(i * 9));
            chk(32'(baud_code), 32'(2 * i));
        end
    endtask
    task automatic t_lss();
        lid = 7'h55;
        pulse(lnw);
        tick();
        lid = 7'h00;
        pulse(lnw);
        tick();
        chk(32'(node_id), 32'h55);
        for (int b = 0; b < 8; b++) begin
            lbs = 3'(b);
            pulse(lbw);
            tick();
            chk(32'(baud_code), (b < 7) ? 32'(b) : 32'h6);
        end
    endtask
    task automatic t_alarm();
        nvm = 1;
        tick(6);
        chk({alarm_nvm, alarm_crc}, 2'b10);
        alarm_clr = 1;
        tick(2);
        chk(alarm_nvm, 1'b1);
        nvm = 0;
        crc = 1;
        tick(6);
        chk({alarm_nvm, alarm_crc}, 2'b01);
        crc = 0;
        tick(6);
        chk({alarm_nvm, alarm_crc}, 2'b00);
        alarm_clr = 0;
    endtask
    task automatic t_poll_full();
        pos_raw = 16'hFFFF;
        pulse(rtr_req);
        exp_frame(3'h2, 32'h1FFF);
        stall = 1;
        pos_raw = 16'h0010;
        rtr_req = 1;
        t0 = 0;
        for (int i = 0; i < 12; i++) begin
            if (i == 5) rtr_req = 0;
            tick();
            if (tx_drop === 1'b1) t0++;
        end
        chk(32'(t0), 32'h1);
        chk(tx_valid, 1'b1);
        stall = 0;
        repeat (4) exp_frame(3'h2, 32'h0002);
        tick(4);
        nfr(0);
    endtask
    task automatic t_sync();
        pos_raw = 16'h1238;
        cfg(pps_sync_cyc, 16'h0, 8'h3, 1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            repeat (2) begin
                pulse(sync_msg);
                tick();
            end
            tick(3);
            nfr(0);
            pulse(sync_msg);
            exp_frame(3'h2, 32'h0247);
        end
        cfg(pps_sync_acyc, 16'h0, 8'h1, 1'b0, 1'b0);
        pos_raw = 16'h4000;
        pulse(sync_msg);
        exp_frame(3'h2, 32'h0800);
        pulse(sync_msg);
        pos_raw = 16'h4001;
        tick(3);
        pulse(sync_msg);
        tick(4);
        nfr(0);
        pos_raw = 16'h4008;
        pulse(sync_msg);
        exp_frame(3'h2, 32'h0801);
    endtask
    task automatic t_cyclic();
        pos_raw = 16'h2468;
        cfg(pps_cyclic, 16'h0001, 8'h1, 1'b0, 1'b0);
        exp_frame(3'h2, 32'h048D);
        t0 = t1;
        exp_frame(3'h2, 32'h048D);
        chk(32'(t1 - t0), 32'd16);
        cfg(pps_poll, 16'h0, 8'h1, 1'b0, 1'b0);
        tick(20);
        nfr(0);
    endtask
    task automatic t_speed();
        pos_raw = 16'h1000;
        cfg(pps_poll, 16'h0, 8'h1, 1'b1, 1'b0);
        wait_upd(t0);
        pos_raw = 16'h1064;
        wait_upd(t1);
        chk(32'(t1 - t0), 32'd80);
        chk(32'(speed_val), 32'h64);
        pulse(rtr_req);
        exp_frame(3'h4, 32'h0064_020C);
        cfg(pps_poll, 16'h0, 8'h1, 1'b1, 1'b1);
        wait_upd(t0);
        wait_upd(t1);
        chk(32'(t1 - t0), 32'd800);
        chk(32'(speed_val), 32'h0);
    endtask

    initial begin
        #200000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        t_straps();
        t_lss();
        t_alarm();
        t_poll_full();
        t_sync();
        t_cyclic();
        t_speed();
        end_of_test();
    end
endmodule
`default_nettype wire

//--- testbench/pps_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module pps_master_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    input wire logic [2:0] tx_len,
    output logic tx_ready
);
    logic [34:0] fq[$];
    int ft[$];
    int cyc = 0;
    // bus master consumes
    // Stall stands in for a busy bus, so the queue must fill
    assign tx_ready = !stall;
    always @(posedge core_clk) begin
        cyc++;
        if (!nrst) begin
            fq.delete();
            ft.delete();
        end else if (tx_valid && tx_ready) begin
            fq.push_back({tx_len, tx_data});
            ft.push_back(cyc);
        end
    end
endmodule
`default_nettype wire
